//--- emam_defs.svh
// Constants for the external memory address map block
`ifndef EMAM_DEFS_SVH
`define EMAM_DEFS_SVH
`define EMAM_INT_AW 24
`define EMAM_EXT_AW 20
`define EMAM_PAGE_HI 23
`define EMAM_PAGE_LO 20
`define EMAM_PAGE_ZERO 4'h0
`define EMAM_ICE_LO 24'hff0000
`define EMAM_ICE_HI 24'hff00ff
`define EMAM_SFR_LO 24'h001f00
`define EMAM_SFR_HI 24'h001fff
`define EMAM_REG_LO 24'h000000
`define EMAM_REG_HI 24'h0001ff
`define EMAM_SMALL_LO 24'hff0000
`define EMAM_SMALL_HI 24'hffffff
`define EMAM_MODE_BIT 1
`define EMAM_MODE_RST 1'b0
`define EMAM_CS0_LO 24'hff0000
`define EMAM_CS0_HI 24'hffffff
`define EMAM_CS1_LO 24'h100000
`define EMAM_CS1_HI 24'h11ffff
`endif

//--- emam_pkg.sv
// Types shared by the external memory address map block
package emam_pkg;
  typedef enum logic [1:0] {
    EMAM_ACC_NONE,
    EMAM_ACC_DATA,
    EMAM_ACC_FETCH,
    EMAM_ACC_XFER
  } emam_acc_t;
  typedef enum logic {
    EMAM_MODE_1M,
    EMAM_MODE_64K
  } emam_mode_t;
endpackage

//--- emam_range_chk.sv
// Address range classifier for internal, reserved and window checks
`timescale 1ns/1ps
`include "emam_defs.svh"
module emam_range_chk (
  input wire logic [23:0] addr, // Internal linear address
  output logic internal_hit, // Served inside or reserved
  output logic small_win_hit, // Inside top 64-Kbyte area
  output logic cs0_hit, // Boot flash region
  output logic cs1_hit // User RAM region
);
  // Range decodes
  always_comb begin
    internal_hit = (addr >= `EMAM_ICE_LO && addr <= `EMAM_ICE_HI) ||
                   (addr >= `EMAM_SFR_LO && addr <= `EMAM_SFR_HI) ||
                   (addr <= `EMAM_REG_HI);
    small_win_hit = addr >= `EMAM_SMALL_LO;
    cs0_hit = addr >= `EMAM_CS0_LO;
    cs1_hit = addr >= `EMAM_CS1_LO && addr <= `EMAM_CS1_HI;
  end
endmodule

//--- emam_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module emam_pin_sync (
  sys_clk, // System clock
  rstn, // Synchronous reset, active low
  pin_in, // Raw pin level
  level_out // Filtered level
);
  input wire logic sys_clk;
  input wire logic rstn;
  input wire logic pin_in;
  output logic level_out;
  logic s1_r;
  logic s2_r;
  logic s3_r;
  // Shift chain
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // Accept a change once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      level_out <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end
endmodule

//--- emam_addr_map.sv
// External memory address map and memory-mode logic
//
// Notes on behaviour
// RQ1: Only address bits 19:0 leave the chip, so sixteen internal pages alias.
// RQ2: Demux mode drives 20 address pins; mux mode shares low 16 with data.
// RQ3: Address bits 19:16 always come out on the extended address port.
// RQ4: The page number is address bits 23:20, sixteen pages of 1 Mbyte.
// RQ5: ICE, peripheral SFR and register-file ranges never start a bus cycle.
// RQ6: Config bit one at 0 picks 1-Mbyte code mode, at 1 the 64-Kbyte mode.
// RQ7: In 1-Mbyte mode code fetches may come from any page.
// RQ8: In 64-Kbyte mode code fetches are allowed only in ff0000-ffffff.
// RQ9: Extended jump, branch and call are refused in 64-Kbyte mode.
// RQ10: Data reaches any page; page 0 is nonextended, others extended.
// RQ11: Boot code after reset comes from the flash on chip select zero.
// RQ12: The user RAM region is enabled by chip select one.
// RQ13: Port 3 pins 0, 1, 2 and 5 stay chip selects; the rest are GPIO.
// RQ14: The host link raises the nonmaskable interrupt for a ready character.
// RQ15: The memory mode is caught at reset and held until the next reset.
`timescale 1ns/1ps
`include "emam_defs.svh"
module emam_addr_map (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [7:0] chip_config_byte_one, // Config byte sampled at reset
  input wire logic demux_mode, // 1 selects demultiplexed bus
  input wire logic req_valid, // Access request strobe
  input wire emam_pkg::emam_acc_t req_kind, // Kind of access
  input wire logic [23:0] req_addr, // Internal linear address
  input wire logic [15:0] req_wdata, // Write data
  input wire logic req_write, // 1 for a write
  input wire logic host_char_pin, // Host link character-ready pin
  input wire logic [7:0] port3_gpio_out, // GPIO values for port 3
  output logic [19:0] ext_address, // Demux address pins
  output logic [15:0] shared_addr_data_bus, // Mux address/data out
  output logic shared_addr_data_oe, // Mux bus output enable
  output logic [3:0] upper_ext_address, // Extended address port pins
  output logic bus_cycle, // External cycle in progress
  output logic ext_cycle_extended, // Extended cycle marker
  output logic internal_access, // Served inside the chip
  output logic fetch_fault, // Fetch or transfer refused
  output logic [3:0] page_num, // Page of the request
  output logic boot_flash_select_n, // Chip select zero
  output logic user_ram_select_n, // Chip select one
  output logic [7:0] port3_out, // Port 3 pin values
  output logic small_code_window_select, // Latched memory mode
  output logic nmi_req // Nonmaskable interrupt request
);
  logic internal_hit;
  logic small_win_hit;
  logic cs0_hit;
  logic cs1_hit;
  logic host_level;
  logic boot_r;
  logic boot_fetch;
  logic go;
  logic refuse;
  emam_pkg::emam_mode_t mode_r;

  //----------------------------------------
  // Range decode and pin synchroniser
  //----------------------------------------
  emam_range_chk u_rng (
    .addr(req_addr),
    .internal_hit(internal_hit),
    .small_win_hit(small_win_hit),
    .cs0_hit(cs0_hit),
    .cs1_hit(cs1_hit)
  );

  emam_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in(host_char_pin),
    .level_out(host_level)
  );

  //----------------------------------------
  // Memory mode latch
  //----------------------------------------
  // Caught while reset is held, frozen afterwards
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode_r <= chip_config_byte_one[`EMAM_MODE_BIT] ? // RQ15
        emam_pkg::EMAM_MODE_64K : emam_pkg::EMAM_MODE_1M; // RQ6
    end
  end
  assign small_code_window_select = (mode_r == emam_pkg::EMAM_MODE_64K);

  // Mode taken from the config bit while reset is held
  mode_latch_a: assert property (@(posedge sys_clk) // RQ6
    !rstn |=> small_code_window_select ==
      $past(chip_config_byte_one[`EMAM_MODE_BIT]))
    else $error("memory mode not taken from config bit");

  // Mode frozen from release until the next reset
  mode_hold_a: assert property (@(posedge sys_clk) // RQ15
    disable iff (!rstn) $stable(small_code_window_select))
    else $error("memory mode changed outside reset");

  // Boot flag: first fetch after reset forced to chip select zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      boot_r <= 1'b1;
    end else if (req_valid && req_kind == emam_pkg::EMAM_ACC_FETCH) begin
      boot_r <= 1'b0;
    end
  end

  // Fetch that the boot flag steers to the flash
  assign boot_fetch = boot_r && req_kind == emam_pkg::EMAM_ACC_FETCH;

  // First fetch after reset lands on the flash
  boot_fetch_a: assert property (@(posedge sys_clk) // RQ11
    disable iff (!rstn)
    go && boot_fetch |=> !boot_flash_select_n)
    else $error("boot fetch missed flash select");

  //----------------------------------------
  // Request qualification
  //----------------------------------------
  always_comb begin
    refuse = 1'b0;
    if (req_kind == emam_pkg::EMAM_ACC_FETCH) begin
      refuse = small_code_window_select && !small_win_hit; // RQ7 RQ8
    end else if (req_kind == emam_pkg::EMAM_ACC_XFER) begin
      refuse = small_code_window_select; // RQ9
    end
  end
  // Internal ranges never reach the bus
  assign go = req_valid && req_kind != emam_pkg::EMAM_ACC_NONE &&
              !refuse && !internal_hit; // RQ5

  // Any page may be fetched in 1-Mbyte mode
  fetch_wide_a: assert property (@(posedge sys_clk) // RQ7
    disable iff (!rstn)
    req_valid && req_kind == emam_pkg::EMAM_ACC_FETCH &&
      !small_code_window_select |=> !fetch_fault)
    else $error("fetch refused in 1-Mbyte mode");

  // Fetch with address bit 23 clear refused in small mode
  small_fetch_a: assert property (@(posedge sys_clk) // RQ8
    disable iff (!rstn)
    req_valid && req_kind == emam_pkg::EMAM_ACC_FETCH &&
      small_code_window_select && !req_addr[23] |=>
      fetch_fault && !bus_cycle)
    else $error("fetch outside small window allowed");

  // Extended transfers refused in small mode
  xfer_refuse_a: assert property (@(posedge sys_clk) // RQ9
    disable iff (!rstn)
    req_valid && req_kind == emam_pkg::EMAM_ACC_XFER &&
      small_code_window_select |=> fetch_fault && !bus_cycle)
    else $error("extended transfer ran in small mode");

  // A refused request never reaches the bus
  fault_nobus_a: assert property (@(posedge sys_clk) // RQ9
    disable iff (!rstn) fetch_fault |-> !bus_cycle)
    else $error("refused request started a bus cycle");

  // Data is never refused, whatever the mode
  data_any_a: assert property (@(posedge sys_clk) // RQ10
    disable iff (!rstn)
    req_valid && req_kind == emam_pkg::EMAM_ACC_DATA |=> !fetch_fault)
    else $error("data access refused");

  // Internal ranges answer inside, never on the bus
  internal_nobus_a: assert property (@(posedge sys_clk) // RQ5
    disable iff (!rstn)
    req_valid && internal_hit |=> internal_access && !bus_cycle)
    else $error("bus cycle for internal range");

  //----------------------------------------
  // Bus outputs
  //----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ext_address <= 20'h00000;
      shared_addr_data_bus <= 16'h0000;
      shared_addr_data_oe <= 1'b0;
      upper_ext_address <= 4'h0;
      bus_cycle <= 1'b0;
      ext_cycle_extended <= 1'b0;
      internal_access <= 1'b0;
      fetch_fault <= 1'b0;
      page_num <= 4'h0;
      boot_flash_select_n <= 1'b1;
      user_ram_select_n <= 1'b1;
    end else begin
      page_num <= req_addr[`EMAM_PAGE_HI:`EMAM_PAGE_LO]; // RQ4
      internal_access <= req_valid && internal_hit;
      fetch_fault <= req_valid && refuse;
      bus_cycle <= go;
      if (go) begin
        ext_address <= demux_mode ? req_addr[19:0] : 20'h00000; // RQ1 RQ2
        upper_ext_address <= req_addr[19:16]; // RQ3
        shared_addr_data_bus <= demux_mode ? req_wdata :
                                req_addr[15:0]; // RQ2
        shared_addr_data_oe <= !demux_mode || req_write;
        ext_cycle_extended <= req_addr[`EMAM_PAGE_HI:`EMAM_PAGE_LO] !=
                              `EMAM_PAGE_ZERO; // RQ10
        boot_flash_select_n <= !(cs0_hit || boot_fetch); // RQ11
        // Boot fetch wins so both parts never drive together
        user_ram_select_n <= !(cs1_hit && !boot_fetch); // RQ12
      end else begin
        shared_addr_data_oe <= 1'b0;
        boot_flash_select_n <= 1'b1;
        user_ram_select_n <= 1'b1;
      end
    end
  end

  // Demux pins carry only the low 20 bits
  addr_alias_a: assert property (@(posedge sys_clk) // RQ1
    disable iff (!rstn)
    go && demux_mode |=> ext_address == $past(req_addr[19:0]))
    else $error("external address not low 20 bits");

  // Demux address pins idle in mux mode
  mux_zero_a: assert property (@(posedge sys_clk) // RQ2
    disable iff (!rstn)
    go && !demux_mode |=> ext_address == 20'h00000)
    else $error("demux pins driven in mux mode");

  // Address bits 19:16 on the extended port
  upper_port_a: assert property (@(posedge sys_clk) // RQ3
    disable iff (!rstn)
    go |=> upper_ext_address == $past(req_addr[19:16]))
    else $error("upper address port wrong");

  // Shared pins carry the low address in mux mode
  mux_addr_a: assert property (@(posedge sys_clk) // RQ2
    disable iff (!rstn)
    go && !demux_mode |=> shared_addr_data_oe &&
      shared_addr_data_bus == $past(req_addr[15:0]))
    else $error("mux address phase wrong");

  // Shared pins driven only for writes in demux mode
  demux_oe_a: assert property (@(posedge sys_clk) // RQ2
    disable iff (!rstn)
    go && demux_mode |=> shared_addr_data_oe == $past(req_write))
    else $error("demux bus enable wrong");

  // Page number from the top four bits
  page_num_a: assert property (@(posedge sys_clk) // RQ4
    disable iff (!rstn)
    req_valid |=> page_num == $past(req_addr[23:20]))
    else $error("page number wrong");

  // Page zero nonextended, all others extended
  page_ext_a: assert property (@(posedge sys_clk) // RQ10
    disable iff (!rstn)
    go |=> ext_cycle_extended == ($past(req_addr[23:20]) != 4'h0))
    else $error("extended cycle marker wrong");

  // Flash region selects the flash alone
  cs0_sel_a: assert property (@(posedge sys_clk) // RQ11
    disable iff (!rstn)
    go && cs0_hit |=> !boot_flash_select_n && user_ram_select_n)
    else $error("flash select wrong");

  // RAM region selects the RAM alone
  cs1_sel_a: assert property (@(posedge sys_clk) // RQ12
    disable iff (!rstn)
    go && cs1_hit && !boot_fetch |=> !user_ram_select_n &&
      boot_flash_select_n)
    else $error("user RAM select wrong");

  // Selects and bus drive drop between cycles
  idle_sel_a: assert property (@(posedge sys_clk) // RQ12
    disable iff (!rstn)
    !go |=> !bus_cycle && !shared_addr_data_oe &&
      boot_flash_select_n && user_ram_select_n)
    else $error("select active without a bus cycle");

  //----------------------------------------
  // Port 3 pins and host interrupt
  //----------------------------------------
  // Chip-select pins override GPIO
  always_comb begin
    port3_out = port3_gpio_out;
    port3_out[0] = boot_flash_select_n; // RQ13
    port3_out[1] = user_ram_select_n; // RQ13
    port3_out[2] = 1'b1;
    port3_out[5] = 1'b1;
  end

  // Chip-select pins are never handed to GPIO
  cs_pins_a: assert property (@(posedge sys_clk) // RQ13
    disable iff (!rstn)
    port3_out[0] == boot_flash_select_n &&
      port3_out[1] == user_ram_select_n && port3_out[2] && port3_out[5])
    else $error("chip select pin overridden");

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      nmi_req <= 1'b0;
    end else begin
      nmi_req <= host_level; // RQ14
    end
  end

  // Interrupt rises with the filtered host line
  nmi_follow_a: assert property (@(posedge sys_clk) // RQ14
    disable iff (!rstn)
    host_level |=> nmi_req)
    else $error("nmi did not follow host link");

  // Interrupt falls with the filtered host line
  nmi_low_a: assert property (@(posedge sys_clk) // RQ14
    disable iff (!rstn)
    !host_level |=> !nmi_req)
    else $error("nmi raised without host character");
endmodule

//--- emam_mem_model.sv
// Boot flash and user RAM seen from the external bus, counting selects
`timescale 1ns/1ps
module emam_mem_model (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic boot_flash_select_n, // Flash chip select
  input wire logic user_ram_select_n, // RAM chip select
  output int flash_hits, // Cycles with flash selected
  output int ram_hits // Cycles with RAM selected
);
  // Count selected cycles; both parts idle during reset
  always @(posedge sys_clk) begin
    if (!rstn) begin
      flash_hits <= 0;
      ram_hits <= 0;
    end else begin
      if (!boot_flash_select_n) flash_hits <= flash_hits + 1;
      if (!user_ram_select_n) ram_hits <= ram_hits + 1;
    end
  end
endmodule

//--- tb_external_memory_address_map.sv
// Self-checking bench for the external memory address map block
`timescale 1ns/1ps
`include "emam_defs.svh"
module tb_external_memory_address_map;
  logic sys_clk = 0;
  logic rstn = 0;
  logic [7:0] cfg = 8'h00;
  logic demux = 0;
  logic req_valid = 0;
  emam_pkg::emam_acc_t kind = emam_pkg::EMAM_ACC_DATA;
  logic [23:0] addr = 24'h0;
  logic [15:0] wdata = 16'h0;
  logic wr = 0;
  logic host_pin = 0;
  logic [7:0] gpio = 8'h00;
  logic [19:0] ext_address;
  logic [15:0] ad_bus;
  logic ad_oe, bus_cycle, ext_x, internal_access, fetch_fault;
  logic [3:0] upper, page_num;
  logic cs0_n, cs1_n, mode, nmi_req;
  logic [7:0] port3_out;
  int miscompares = 0;
  int checks_done = 0;
  int exp_flash, exp_ram, flash_hits, ram_hits;
  logic [31:0] seed = 32'h4d5f63b7;
  logic boot_exp = 0;
  logic [23:0] corners [10] = '{24'hff2018, 24'h0001ff, 24'h000200,
    24'h001eff, 24'h001f00, 24'hff00ff, 24'hff0100, 24'h11ffff,
    24'h120000, 24'h0fffff};

  emam_addr_map u_dut (.sys_clk(sys_clk), .rstn(rstn),
    .chip_config_byte_one(cfg), .demux_mode(demux), .req_valid(req_valid),
    .req_kind(kind), .req_addr(addr), .req_wdata(wdata), .req_write(wr),
    .host_char_pin(host_pin), .port3_gpio_out(gpio),
    .ext_address(ext_address), .shared_addr_data_bus(ad_bus),
    .shared_addr_data_oe(ad_oe), .upper_ext_address(upper),
    .bus_cycle(bus_cycle), .ext_cycle_extended(ext_x),
    .internal_access(internal_access), .fetch_fault(fetch_fault),
    .page_num(page_num), .boot_flash_select_n(cs0_n),
    .user_ram_select_n(cs1_n), .port3_out(port3_out),
    .small_code_window_select(mode), .nmi_req(nmi_req));
  emam_mem_model u_mem (.sys_clk(sys_clk), .rstn(rstn),
    .boot_flash_select_n(cs0_n), .user_ram_select_n(cs1_n),
    .flash_hits(flash_hits), .ram_hits(ram_hits));

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  // Repeatable random source
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction

  // Expected {fault, internal, bus, extended, cs0, cs1}
  function automatic logic [5:0] expect_of(logic m, emam_pkg::emam_acc_t k,
      logic [23:0] a);
    logic f, i;
    f = m && (k == emam_pkg::EMAM_ACC_XFER ||
      (k == emam_pkg::EMAM_ACC_FETCH && a < `EMAM_SMALL_LO));
    i = a <= `EMAM_REG_HI || (a >= `EMAM_SFR_LO && a <= `EMAM_SFR_HI) ||
      (a >= `EMAM_ICE_LO && a <= `EMAM_ICE_HI);
    if (f) return 6'h20;
    if (i) return 6'h10;
    return {3'b001, a[23:20] != 4'h0, a >= `EMAM_CS0_LO,
      a >= `EMAM_CS1_LO && a <= `EMAM_CS1_HI};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One request at a falling edge, checked one cycle later
  task automatic access(input logic m, input emam_pkg::emam_acc_t k,
      input logic [23:0] a);
    logic [5:0] e;
    logic [7:0] p3;
    e = expect_of(m, k, a);
    // The first fetch after reset is steered to the boot flash
    if (boot_exp && k == emam_pkg::EMAM_ACC_FETCH && e[3]) e[1:0] = 2'b10;
    if (k == emam_pkg::EMAM_ACC_FETCH) boot_exp = 0;
    req_valid = 1;
    kind = k;
    addr = a;
    seed = xs(seed);
    wdata = seed[15:0];
    wr = seed[16];
    gpio = seed[31:24];
    @(negedge sys_clk);
    chk("fault", e[5], fetch_fault);
    if (!e[5]) chk("internal", e[4], internal_access);
    chk("bus", e[3], bus_cycle);
    chk("page", a[23:20], page_num);
    if (e[3]) begin
      exp_flash += e[1];
      exp_ram += e[0];
      chk("extended", e[2], ext_x);
      chk("cs0_n", !e[1], cs0_n);
      chk("cs1_n", !e[0], cs1_n);
      chk("upper", a[19:16], upper);
      chk("ext_addr", demux ? a[19:0] : 20'h0, ext_address);
      chk("ad_bus", demux ? wdata : a[15:0], ad_bus);
      chk("ad_oe", demux ? wr : 1'b1, ad_oe);
      p3 = {gpio[7:6], 1'b1, gpio[4:3], 1'b1, !e[0], !e[1]};
      chk("port3", p3, port3_out);
    end else chk("sel_n", 3'b110, {cs0_n, cs1_n, ad_oe});
  endtask

  // Reset with a mode, then corners and random traffic back to back
  task automatic run_phase(input logic m);
    rstn = 0;
    req_valid = 0;
    cfg = {6'h00, m, 1'b0};
    repeat (6) @(negedge sys_clk);
    rstn = 1;
    cfg = ~cfg;
    exp_flash = 0;
    exp_ram = 0;
    boot_exp = 1;
    access(m, emam_pkg::EMAM_ACC_FETCH, m ? 24'hff2018 : 24'h0f2018);
    for (int i = 0; i < 60; i++) begin
      demux = i[0];
      access(m, emam_pkg::emam_acc_t'(2'(i % 3 + 1)), corners[i % 10]);
    end
    for (int i = 0; i < 300; i++) begin
      seed = xs(seed);
      demux = seed[3];
      case (seed[1:0])
        2'd0: addr = seed[31:8];
        2'd1: addr = {8'hff, seed[31:16]};
        2'd2: addr = {11'h000, seed[31:19]};
        default: addr = {7'h08, seed[31:15]};
      endcase
      access(m, emam_pkg::emam_acc_t'(2'(seed[7:6] % 3 + 1)), addr);
    end
    req_valid = 0;
    @(negedge sys_clk);
    chk("mode", m, mode);
    chk("flash_hits", exp_flash, flash_hits);
    chk("ram_hits", exp_ram, ram_hits);
  endtask

  // Host character ready must reach the interrupt within a bound
  task automatic host_link(input logic lvl);
    int k;
    host_pin = lvl;
    k = 0;
    while (nmi_req !== lvl && k < 8) begin
      @(negedge sys_clk);
      k++;
    end
    chk("nmi_req", lvl, nmi_req);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    run_phase(1'b0);
    run_phase(1'b1);
    host_link(1'b1);
    host_link(1'b0);
    report_and_stop;
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    report_and_stop;
  end
endmodule
